// ### rtl/angle_pkg.sv
// constants, types and layout shared by the angle readout block
// Functional notes
// - angle is computed from the two axes picked by the axis pair field.
// - angle result spans a full 360 degree turn, no folding.
// - gain field is a fraction, field value over 1024, scaling one axis.
// - gain select 00b means no correction; gain value ignored.
// - gain select 01b scales the X axis data feeding the angle.
// - gain select 10b scales the Y axis data instead of X.
// - result registers change only when a conversion finishes.
// - alert output tells the host a conversion has completed.
package angle_pkg;
  localparam int SAMPLE_W = 16;
  localparam int GAIN_W = 10;
  localparam int GAIN_SHIFT = 10;
  localparam int ANG_W = 14;
  localparam int MAG_W = 18;
  localparam int ITER = 11;
  localparam int ADDR_W = 6;
  // angle unit is 1/16 degree
  localparam logic [ANG_W-1:0] DEG_180 = 14'h0B40;
  localparam logic [ANG_W-1:0] DEG_360 = 14'h1680;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_ANGLE_CFG = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_AMP_CFG = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_X_RES = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_Y_RES = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_Z_RES = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_ANGLE_RES = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_MAG_RES = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_CLEAR = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 6'h24;
  // field positions
  localparam int PAIR_LSB = 0;
  localparam int GAIN_VAL_LSB = 0;
  localparam int GAIN_SEL_LSB = 10;
  localparam int ST_DONE = 0;
  localparam int ST_OVERRUN = 1;
  localparam int ST_W = 2;
  // reset values
  localparam logic [1:0] PAIR_RST = 2'h0;
  localparam logic [1:0] GAIN_SEL_RST = 2'h0;
  localparam logic [GAIN_W-1:0] GAIN_VAL_RST = 10'h000;
  localparam logic [ST_W-1:0] ENABLE_RST = 2'h0;
  // alert pulse timing
  localparam int CLK_NS = 40;
  localparam int ALERT_NS = 200;
  localparam int ALERT_CYC = (ALERT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    GAIN_NONE = 2'h0,
    GAIN_X = 2'h1,
    GAIN_Y = 2'h2
  } gain_sel_t;
  typedef enum logic [1:0] {
    PAIR_XY = 2'h0,
    PAIR_YZ = 2'h1,
    PAIR_XZ = 2'h2
  } pair_t;
  typedef enum logic [1:0] {
    CORD_IDLE = 2'b01,
    CORD_RUN = 2'b10
  } cord_state_t;
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] x;
    logic signed [SAMPLE_W-1:0] y;
    logic signed [SAMPLE_W-1:0] z;
  } sample_t;
  typedef struct packed {
    logic [GAIN_W-1:0] value;
    logic [1:0] sel;
  } gain_cfg_t;
endpackage : angle_pkg

// ### rtl/gain_stage.sv
// one-cycle fractional gain on the x or y axis of a sample
`timescale 1ns/1ps
`default_nettype none
module gain_stage (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  input wire angle_pkg::sample_t in_sample,
  input wire angle_pkg::gain_cfg_t cfg,
  output logic out_valid,
  output angle_pkg::sample_t out_sample
);
  // value * g / 1024, g below one so the result never grows
  function automatic logic signed [angle_pkg::SAMPLE_W-1:0] scale(
    input logic signed [angle_pkg::SAMPLE_W-1:0] v,
    input logic [angle_pkg::GAIN_W-1:0] g);
    logic signed [angle_pkg::SAMPLE_W+angle_pkg::GAIN_W:0] p;
    p = v * $signed({1'b0, g});
    scale = p[angle_pkg::GAIN_SHIFT +: angle_pkg::SAMPLE_W];
  endfunction : scale

  // valid follows input by one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid;
    end
  end

  // sample with the chosen axis scaled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_sample <= '0;
    end else if (in_valid) begin
      out_sample <= in_sample;
      case (angle_pkg::gain_sel_t'(cfg.sel))
        angle_pkg::GAIN_X: out_sample.x <= scale(in_sample.x, cfg.value);
        angle_pkg::GAIN_Y: out_sample.y <= scale(in_sample.y, cfg.value);
        default: out_sample <= in_sample;
      endcase
    end
  end
endmodule : gain_stage
`default_nettype wire

// ### rtl/angle_cordic.sv
// iterative vectoring cordic giving angle over a full turn and magnitude
`timescale 1ns/1ps
`default_nettype none
module angle_cordic (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic signed [angle_pkg::SAMPLE_W-1:0] a_in,
  input wire logic signed [angle_pkg::SAMPLE_W-1:0] b_in,
  output logic done,
  output logic [angle_pkg::ANG_W-1:0] angle,
  output logic [angle_pkg::MAG_W-1:0] mag
);
  localparam int W = angle_pkg::MAG_W;
  localparam int AW = angle_pkg::ANG_W;
  angle_pkg::cord_state_t state_q;
  logic signed [W-1:0] x_q;
  logic signed [W-1:0] y_q;
  logic signed [AW-1:0] z_q;
  logic [3:0] it_q;

  // arctan(2^-i) in 1/16 degree
  function automatic logic signed [AW-1:0] atan_step(input logic [3:0] i);
    case (i)
      4'h0: atan_step = 14'sh02D0;
      4'h1: atan_step = 14'sh01A9;
      4'h2: atan_step = 14'sh00E1;
      4'h3: atan_step = 14'sh0072;
      4'h4: atan_step = 14'sh0039;
      4'h5: atan_step = 14'sh001D;
      4'h6: atan_step = 14'sh000E;
      4'h7: atan_step = 14'sh0007;
      4'h8: atan_step = 14'sh0004;
      4'h9: atan_step = 14'sh0002;
      default: atan_step = 14'sh0001;
    endcase
  endfunction : atan_step

  // rotate b towards zero; negative a pre-rotated by 180 degrees
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= angle_pkg::CORD_IDLE;
      x_q <= '0;
      y_q <= '0;
      z_q <= '0;
      it_q <= 4'h0;
      done <= 1'b0;
      angle <= '0;
      mag <= '0;
    end else begin
      done <= 1'b0;
      case (state_q)
        angle_pkg::CORD_IDLE: begin
          if (start) begin
            it_q <= 4'h0;
            state_q <= angle_pkg::CORD_RUN;
            if (a_in < 0) begin
              x_q <= -W'(a_in);
              y_q <= -W'(b_in);
              z_q <= $signed(angle_pkg::DEG_180);
            end else begin
              x_q <= W'(a_in);
              y_q <= W'(b_in);
              z_q <= '0;
            end
          end
        end
        angle_pkg::CORD_RUN: begin
          if (y_q < 0) begin
            x_q <= x_q - (y_q >>> it_q);
            y_q <= y_q + (x_q >>> it_q);
            z_q <= z_q - atan_step(it_q);
          end else begin
            x_q <= x_q + (y_q >>> it_q);
            y_q <= y_q - (x_q >>> it_q);
            z_q <= z_q + atan_step(it_q);
          end
          if (it_q == 4'(angle_pkg::ITER - 1)) begin
            state_q <= angle_pkg::CORD_IDLE;
            done <= 1'b1;
          end else begin
            it_q <= it_q + 4'h1;
          end
        end
        default: state_q <= angle_pkg::CORD_IDLE;
      endcase
      // wrap negative angles into 0..360
      if (state_q == angle_pkg::CORD_RUN && it_q == 4'(angle_pkg::ITER - 1)) begin
        angle <= (z_q < 0) ? AW'(z_q + $signed(angle_pkg::DEG_360)) : z_q;
        mag <= x_q;
      end
    end
  end
endmodule : angle_cordic
`default_nettype wire

// ### rtl/angle_readout.sv
// angle readout top: gain, cordic, result registers, alert and axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
module angle_readout #(
  parameter int SAMPLE_W = 16,
  parameter int ALERT_CYC = angle_pkg::ALERT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [angle_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [angle_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic conv_done,
  input wire angle_pkg::sample_t conv_sample,
  output logic alert,
  output logic irq
);
  // the datapath is built for the packed sample width only
  if (SAMPLE_W != angle_pkg::SAMPLE_W) begin : g_chk_w
    $error("SAMPLE_W must match the package sample width");
  end
  if (ALERT_CYC < 1 || ALERT_CYC > 255) begin : g_chk_alert
    $error("ALERT_CYC must lie in 1..255");
  end

  typedef enum logic [3:0] {
    SEL_NONE, SEL_ANGLE_CFG, SEL_AMP_CFG, SEL_X, SEL_Y, SEL_Z,
    SEL_ANGLE, SEL_MAG, SEL_STATUS, SEL_CLEAR, SEL_ENABLE
  } reg_sel_t;

  // address decode shared by read and write paths
  function automatic reg_sel_t decode(input logic [angle_pkg::ADDR_W-1:0] a);
    if (a == angle_pkg::OFS_ANGLE_CFG) begin
      decode = SEL_ANGLE_CFG;
    end else if (a == angle_pkg::OFS_AMP_CFG) begin
      decode = SEL_AMP_CFG;
    end else if (a == angle_pkg::OFS_X_RES) begin
      decode = SEL_X;
    end else if (a == angle_pkg::OFS_Y_RES) begin
      decode = SEL_Y;
    end else if (a == angle_pkg::OFS_Z_RES) begin
      decode = SEL_Z;
    end else if (a == angle_pkg::OFS_ANGLE_RES) begin
      decode = SEL_ANGLE;
    end else if (a == angle_pkg::OFS_MAG_RES) begin
      decode = SEL_MAG;
    end else if (a == angle_pkg::OFS_STATUS) begin
      decode = SEL_STATUS;
    end else if (a == angle_pkg::OFS_CLEAR) begin
      decode = SEL_CLEAR;
    end else if (a == angle_pkg::OFS_ENABLE) begin
      decode = SEL_ENABLE;
    end else begin
      decode = SEL_NONE;
    end
  endfunction : decode

  // merge write data into a word under the byte strobes
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[8*i +: 8] = data[8*i +: 8];
      end
    end
  endfunction : merge

  // write channel holding registers
  logic aw_have_q;
  logic w_have_q;
  logic [angle_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  reg_sel_t wr_sel;
  reg_sel_t rd_sel;

  // configuration and result state
  logic [1:0] pair_q;
  angle_pkg::gain_cfg_t gain_cfg_q;
  logic [31:0] amp_word;
  logic [31:0] amp_new;
  angle_pkg::sample_t raw_q;
  angle_pkg::sample_t res_q;
  logic [angle_pkg::ANG_W-1:0] angle_res_q;
  logic [angle_pkg::MAG_W-1:0] mag_res_q;
  logic [angle_pkg::ST_W-1:0] status_q;
  logic [angle_pkg::ST_W-1:0] status_d;
  logic [angle_pkg::ST_W-1:0] enable_q;
  logic [angle_pkg::ST_W-1:0] clr;
  logic [angle_pkg::ST_W-1:0] set;
  logic busy_q;
  logic accept;
  logic [7:0] alert_cnt_q;

  // datapath links
  logic gain_valid;
  angle_pkg::sample_t gain_sample;
  logic signed [angle_pkg::SAMPLE_W-1:0] a_sel;
  logic signed [angle_pkg::SAMPLE_W-1:0] b_sel;
  logic cord_done;
  logic [angle_pkg::ANG_W-1:0] cord_angle;
  logic [angle_pkg::MAG_W-1:0] cord_mag;

  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_sel = decode(awaddr_q);
  assign rd_sel = decode(s_axi_araddr);

  // write address channel: one address held until the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_have_q <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  // write data channel, independent of the address order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_have_q <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // write response once both halves are in; read-only targets error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= angle_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (wr_sel == SEL_ANGLE_CFG || wr_sel == SEL_AMP_CFG ||
          wr_sel == SEL_CLEAR || wr_sel == SEL_ENABLE) begin
        s_axi_bresp <= angle_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= angle_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // axis pair for the angle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pair_q <= angle_pkg::PAIR_RST;
    end else if (wr_fire && wr_sel == SEL_ANGLE_CFG && wstrb_q[0]) begin
      pair_q <= wdata_q[angle_pkg::PAIR_LSB +: 2];
    end
  end

  // gain configuration word
  assign amp_word = {20'h00000, gain_cfg_q.sel, gain_cfg_q.value};
  assign amp_new = merge(amp_word, wdata_q, wstrb_q);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gain_cfg_q.sel <= angle_pkg::GAIN_SEL_RST;
      gain_cfg_q.value <= angle_pkg::GAIN_VAL_RST;
    end else if (wr_fire && wr_sel == SEL_AMP_CFG) begin
      gain_cfg_q.sel <= amp_new[angle_pkg::GAIN_SEL_LSB +: 2];
      gain_cfg_q.value <= amp_new[angle_pkg::GAIN_VAL_LSB +: angle_pkg::GAIN_W];
    end
  end

  // interrupt enable register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= angle_pkg::ENABLE_RST;
    end else if (wr_fire && wr_sel == SEL_ENABLE && wstrb_q[0]) begin
      enable_q <= wdata_q[angle_pkg::ST_W-1:0];
    end
  end

  // read channel; rdata registered at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= angle_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= angle_pkg::RESP_OKAY;
      s_axi_rdata <= '0;
      if (rd_sel == SEL_ANGLE_CFG) begin
        s_axi_rdata <= {30'h00000000, pair_q};
      end else if (rd_sel == SEL_AMP_CFG) begin
        s_axi_rdata <= amp_word;
      end else if (rd_sel == SEL_X) begin
        s_axi_rdata <= {{16{res_q.x[15]}}, res_q.x};
      end else if (rd_sel == SEL_Y) begin
        s_axi_rdata <= {{16{res_q.y[15]}}, res_q.y};
      end else if (rd_sel == SEL_Z) begin
        s_axi_rdata <= {{16{res_q.z[15]}}, res_q.z};
      end else if (rd_sel == SEL_ANGLE) begin
        s_axi_rdata <= {18'h00000, angle_res_q};
      end else if (rd_sel == SEL_MAG) begin
        s_axi_rdata <= {14'h0000, mag_res_q};
      end else if (rd_sel == SEL_STATUS) begin
        s_axi_rdata <= {30'h00000000, status_q};
      end else if (rd_sel == SEL_ENABLE) begin
        s_axi_rdata <= {30'h00000000, enable_q};
      end else if (rd_sel == SEL_NONE) begin
        s_axi_rresp <= angle_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // a conversion is taken only while the angle path is free
  assign accept = conv_done && !busy_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
    end else if (accept) begin
      busy_q <= 1'b1;
    end else if (cord_done) begin
      busy_q <= 1'b0;
    end
  end

  // raw axes wait here so results appear together with the angle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_q <= '0;
    end else if (accept) begin
      raw_q <= conv_sample;
    end
  end

  gain_stage u_gain (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(accept),
    .in_sample(conv_sample),
    .cfg(gain_cfg_q),
    .out_valid(gain_valid),
    .out_sample(gain_sample)
  );

  // pick cosine and sine axes from the selected pair
  always_comb begin
    a_sel = gain_sample.x;
    b_sel = gain_sample.y;
    case (angle_pkg::pair_t'(pair_q))
      angle_pkg::PAIR_YZ: begin
        a_sel = gain_sample.y;
        b_sel = gain_sample.z;
      end
      angle_pkg::PAIR_XZ: begin
        a_sel = gain_sample.x;
        b_sel = gain_sample.z;
      end
      default: begin
        a_sel = gain_sample.x;
        b_sel = gain_sample.y;
      end
    endcase
  end

  angle_cordic u_cordic (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(gain_valid),
    .a_in(a_sel),
    .b_in(b_sel),
    .done(cord_done),
    .angle(cord_angle),
    .mag(cord_mag)
  );

  // results move only at conversion end, reads see old values till then
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_q <= '0;
      angle_res_q <= '0;
      mag_res_q <= '0;
    end else if (cord_done) begin
      res_q <= raw_q;
      angle_res_q <= cord_angle;
      mag_res_q <= cord_mag;
    end
  end

  // sticky status; a set in the clearing cycle survives
  always_comb begin
    set = '0;
    set[angle_pkg::ST_DONE] = cord_done;
    set[angle_pkg::ST_OVERRUN] = conv_done && busy_q;
    clr = '0;
    if (wr_fire && wr_sel == SEL_CLEAR && wstrb_q[0]) begin
      clr = wdata_q[angle_pkg::ST_W-1:0];
    end
    status_d = (status_q & ~clr) | set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  // level interrupt from enabled status bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_d & enable_q);
    end
  end

  // alert pulse of fixed length when fresh results land
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alert_cnt_q <= 8'h00;
      alert <= 1'b0;
    end else if (cord_done) begin
      alert_cnt_q <= 8'(ALERT_CYC - 1);
      alert <= 1'b1;
    end else if (alert_cnt_q != 8'h00) begin
      alert_cnt_q <= alert_cnt_q - 8'h01;
    end else begin
      alert <= 1'b0;
    end
  end
endmodule : angle_readout
`default_nettype wire

// ### sim/angle_readout_sva.sv
// port checker for the angle readout block
`timescale 1ns/1ps
`default_nettype none
module angle_readout_sva #(
  parameter int ALERT_CYC = angle_pkg::ALERT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic conv_done,
  input wire logic alert
);
  logic [7:0] alert_len_q;
  // alert length counted here, too long for a repetition
  always_ff @(posedge aclk) begin
    if (!aresetn || !alert) alert_len_q <= 8'h00;
    else alert_len_q <= alert_len_q + 8'h01;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_alert_len; $fell(alert) |-> alert_len_q == ALERT_CYC; endproperty
  a_alert_len: assert property (p_alert_len) else $error("alert pulse length wrong");
  property p_alert_cause; $rose(alert) |-> $past(conv_done, 14) || $past(conv_done, 15);
  endproperty
  a_alert_cause: assert property (p_alert_cause) else $error("alert without conversion");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_b_after; $rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready; endproperty
  a_b_after: assert property (p_b_after) else $error("write response before both parts");
  property p_r_next; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_next: assert property (p_r_next) else $error("read answer late");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_r_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_r_block: assert property (p_r_block) else $error("second read accepted");
  property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
  a_r_done: assert property (p_r_done) else $error("read channel not freed");
endmodule : angle_readout_sva
bind angle_readout angle_readout_sva #(.ALERT_CYC(ALERT_CYC)) u_sva (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .conv_done(conv_done),
  .alert(alert));
`default_nettype wire

// ### sim/axi_host.sv
// host controller model: axi4-lite master, gain calibration, alert sync
`timescale 1ns/1ps
`default_nettype none
module axi_host (
  input wire logic aclk,
  output logic [5:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [5:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready,
  input wire logic alert
);
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
  end
  // ready is raised late by lag cycles to exercise held answers
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input int lag,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk); // an edge between transfers
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (lag == 0);
    forever begin
      @(posedge aclk);
      if (bvalid && bready) break;
      if (awvalid && awready) awvalid <= 1'b0;
      if (awvalid && awready) awaddr <= ~a;
      if (wvalid && wready) wvalid <= 1'b0;
      if (wvalid && wready) wdata <= ~d;
      n++;
      if (n >= lag) bready <= 1'b1;
    end
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input int lag, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (lag == 0);
    forever begin
      @(posedge aclk);
      if (rvalid && rready) break;
      if (arvalid && arready) arvalid <= 1'b0;
      if (arvalid && arready) araddr <= ~a;
      n++;
      if (n >= lag) rready <= 1'b1;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  // reads wait for alert so they never catch stale results
  task automatic sync();
    do @(posedge aclk); while (!alert);
  endtask : sync
  // gain from peak-peak amplitudes, reciprocal on y when ratio exceeds one
  function automatic logic [11:0] gain_of(input int ax, input int ay);
    if (ay < ax) return {2'h1, 10'(ay * 1024 / ax)};
    return {2'h2, 10'(ax * 1024 / ay)};
  endfunction : gain_of
endmodule : axi_host
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench for the angle readout block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic aclk, aresetn, conv_done, alert, irq;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_q, seed, prev_x;
  logic [1:0] bresp, rresp, rsp;
  logic [11:0] cfg;
  angle_pkg::sample_t conv_sample;
  int n_fail, num_checks, x, y, z, d, en;
  angle_readout #(.ALERT_CYC(3)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conv_done(conv_done), .conv_sample(conv_sample), .alert(alert), .irq(irq));
  axi_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .alert(alert));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  function automatic int rnd(input int m);
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed % m);
  endfunction : rnd
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // reference angle in 1/16 degree; floor gain matches the fixed-point multiplier
  function automatic int exp_ang(int x, int y, int z, int p, int s, int g);
    real r;
    if (s == 1) x = (x * g) >>> 10;
    if (s == 2) y = (y * g) >>> 10;
    r = $atan2((p == 1 || p == 2) ? z : y, (p == 1) ? y : x) * 180.0 / 3.14159265358979;
    if (r < 0.0) r += 360.0;
    return int'(r * 16.0) % 5760;
  endfunction : exp_ang
  // one conversion request with a fresh sample
  task automatic convert();
    @(posedge aclk);
    conv_sample <= {16'(x), 16'(y), 16'(z)};
    conv_done <= 1'b1;
    @(posedge aclk);
    conv_done <= 1'b0;
    conv_sample <= ~conv_sample;
  endtask : convert
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    end_sim();
  end
  initial begin
    {aresetn, conv_done, conv_sample, n_fail, num_checks, prev_x} = '0;
    seed = 32'hcbda;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    host.rd(angle_pkg::OFS_ANGLE_CFG, 0, rd_q, rsp);
    check("angle_cfg_rst", rd_q, 32'h0);
    host.rd(angle_pkg::OFS_AMP_CFG, 2, rd_q, rsp);
    check("amp_cfg_rst", rd_q, 32'h0);
    host.rd(6'h28, 1, rd_q, rsp);
    check("unmapped_resp", rsp, angle_pkg::RESP_SLVERR);
    host.wr(angle_pkg::OFS_ANGLE_RES, 32'h5A5, 2, rsp);
    check("ro_write_resp", rsp, angle_pkg::RESP_SLVERR);
    // every pair code against every gain mode, irq enable random
    for (int p = 0; p < 4; p++) begin
      for (int k = 0; k < 3; k++) begin
        d = rnd(30000) + 8000;
        cfg = (k == 2) ? host.gain_of(d, 40000) : host.gain_of(40000, d);
        if (k == 0) cfg = {2'(3 * (p % 2)), 10'(rnd(1024))};
        en = rnd(2);
        x = rnd(30000) - 15000;
        y = rnd(30000) - 15000;
        z = rnd(30000) - 15000;
        host.wr(angle_pkg::OFS_ANGLE_CFG, 32'(p), rnd(3), rsp);
        host.wr(angle_pkg::OFS_AMP_CFG, {20'h0, cfg}, rnd(3), rsp);
        host.wr(angle_pkg::OFS_ENABLE, 32'(en), 0, rsp);
        convert();
        host.rd(angle_pkg::OFS_X_RES, 0, rd_q, rsp);
        check("x_before_update", rd_q, prev_x);
        host.sync();
        host.rd(angle_pkg::OFS_X_RES, rnd(3), rd_q, rsp);
        prev_x = 32'(x);
        check("x_after_update", rd_q, prev_x);
        host.rd(angle_pkg::OFS_ANGLE_RES, 0, rd_q, rsp);
        d = (int'(rd_q) - exp_ang(x, y, z, p, cfg[11:10], cfg[9:0]) + 5760) % 5760;
        check("angle", 32'((d <= 6 || d >= 5754) && !$isunknown(rd_q)), 32'h1);
        host.rd(angle_pkg::OFS_STATUS, 0, rd_q, rsp);
        check("status_done", rd_q, 32'h1);
        check("irq_level", 32'(irq), 32'(en));
        host.wr(angle_pkg::OFS_CLEAR, 32'h3, 0, rsp);
        host.rd(angle_pkg::OFS_STATUS, 0, rd_q, rsp);
        check("status_clear", rd_q, 32'h0);
        check("irq_clear", 32'(irq), 32'h0);
      end
    end
    // second request while busy is dropped and flagged
    convert();
    x = 1000;
    convert();
    host.sync();
    host.rd(angle_pkg::OFS_STATUS, 0, rd_q, rsp);
    check("status_overrun", rd_q, 32'h3);
    host.rd(angle_pkg::OFS_X_RES, 0, rd_q, rsp);
    check("x_kept", rd_q, prev_x);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
